// [design/sfp_host.sv]
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module sfp_host
	import sfp_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [7:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// Interrupt
	output logic o_irq,
	// Link to device
	sfp_if.host lnk
);
	logic [31:0] freq_ff; // Base frequency word
	logic [31:0] chan_ff; // Channel, mantissa, exponent
	logic [4:0] ifrq_ff; // IF setting
	logic [15:0] ctrl_ff; // Control fields
	logic [2:0] irqs_ff; // Sticky events
	logic [2:0] mask_ff; // Event mask
	logic cal_ff; // One-cycle strobe
	logic [7:0] pwd_ff; // Table write data
	logic pwe_ff; // Table write pulse
	logic pwa_ff; // Table write entry
	logic busy_d_ff; // Previous busy
	logic pin_d_ff; // Previous lock pin
	logic wr_ff; // Data phase is write
	logic [7:0] adr_ff; // Data phase address
	logic [31:0] rd_ff; // Read data

	wire take = i_hsel & i_hready & i_htrans[1];
	wire idle = (lnk.radio_state == 2'(SFP_IDLE));
	// Strobe honoured only in IDLE; device relies on this
	wire cal_go = wr_ff && adr_ff == OFF_CTRL && i_hwdata[CTRL_CAL] && idle;
	wire ev_done = busy_d_ff & ~lnk.cal_busy;
	wire ev_fail = ev_done & (lnk.synth_cal_result == CAL_FAIL);
	wire ev_lock = lnk.general_output_pin & ~pin_d_ff;
	wire [2:0] ev = {ev_lock, ev_fail, ev_done};
	wire rd_irq = take & ~i_hwrite & (i_haddr == OFF_IRQS);
	// Frequency writes dropped outside IDLE
	wire fwr = wr_ff & idle;

	// Bus data phase capture
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_ff <= 1'b0;
			adr_ff <= 8'h00;
		end else begin
			wr_ff <= take & i_hwrite;
			adr_ff <= i_haddr;
		end
	end

	// Writable registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			freq_ff <= 32'h0000_0000;
			chan_ff <= 32'h0000_0000;
			ifrq_ff <= 5'h00;
			ctrl_ff <= 16'h0000;
			mask_ff <= 3'h0;
		end else begin
			if (fwr && adr_ff == OFF_FREQ) freq_ff <= i_hwdata;
			if (fwr && adr_ff == OFF_CHAN) chan_ff <= i_hwdata;
			if (fwr && adr_ff == OFF_IFRQ) ifrq_ff <= i_hwdata[4:0];
			if (wr_ff && adr_ff == OFF_CTRL) ctrl_ff <= i_hwdata[15:0];
			if (wr_ff && adr_ff == OFF_MASK) mask_ff <= i_hwdata[2:0];
		end
	end

	// Strobes, table writes, sticky events
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cal_ff <= 1'b0;
			pwe_ff <= 1'b0;
			pwa_ff <= 1'b0;
			pwd_ff <= 8'h00;
			irqs_ff <= 3'h0;
			busy_d_ff <= 1'b0;
			pin_d_ff <= 1'b0;
		end else begin
			cal_ff <= cal_go;
			pwe_ff <= wr_ff & (adr_ff == OFF_PWR0 || adr_ff == OFF_PWR1);
			pwa_ff <= (adr_ff == OFF_PWR1);
			pwd_ff <= i_hwdata[7:0];
			busy_d_ff <= lnk.cal_busy;
			pin_d_ff <= lnk.general_output_pin;
			// New events win over read clear
			irqs_ff <= (rd_irq ? 3'h0 : irqs_ff) | ev;
		end
	end

	// Read mux, registered for data phase
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rd_ff <= 32'h0000_0000;
		end else if (take & ~i_hwrite) begin
			case (i_haddr)
				OFF_FREQ: rd_ff <= freq_ff;
				OFF_CHAN: rd_ff <= chan_ff;
				OFF_IFRQ: rd_ff <= {27'h0, ifrq_ff};
				OFF_CTRL: rd_ff <= {16'h0000, ctrl_ff};
				OFF_STAT: rd_ff <= {22'h0, lnk.synth_cal_result,
					lnk.radio_state, lnk.cal_busy, lnk.general_output_pin};
				OFF_IRQS: rd_ff <= {29'h0, irqs_ff};
				OFF_MASK: rd_ff <= {29'h0, mask_ff};
				OFF_PWR0: rd_ff <= {24'h0, lnk.pa_power};
				OFF_CARR: rd_ff <= lnk.carrier_word;
				default: rd_ff <= 32'h0000_0000;
			endcase
		end
	end

	assign o_hrdata = rd_ff;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_irq = |(irqs_ff & mask_ff);
	assign lnk.freq_word = freq_ff[23:0];
	assign lnk.channel_number = chan_ff[7:0];
	assign lnk.chan_spacing_mantissa = chan_ff[15:8];
	assign lnk.chan_spacing_exponent = chan_ff[17:16];
	assign lnk.if_freq_setting = ifrq_ff;
	assign lnk.auto_cal_select = ctrl_ff[5:4];
	assign lnk.output_pin_select = ctrl_ff[13:8];
	assign lnk.power_table_index = {2'b00, ctrl_ff[14]};
	assign lnk.radio_on = ctrl_ff[CTRL_ON];
	assign lnk.sleep_req = ctrl_ff[CTRL_SLEEP];
	assign lnk.tx_data = ctrl_ff[CTRL_DATA];
	assign lnk.calibrate_strobe = cal_ff;
	assign lnk.pwr_wr_en = pwe_ff;
	assign lnk.pwr_wr_addr = pwa_ff;
	assign lnk.pwr_wr_data = pwd_ff;
endmodule : sfp_host

// [inc/sfp_pkg.sv]
package sfp_pkg;
	// Register bus offsets (byte addresses, one aligned word each)
	localparam logic [7:0] OFF_FREQ = 8'h00;
	localparam logic [7:0] OFF_CHAN = 8'h04;
	localparam logic [7:0] OFF_IFRQ = 8'h08;
	localparam logic [7:0] OFF_CTRL = 8'h0C;
	localparam logic [7:0] OFF_STAT = 8'h10;
	localparam logic [7:0] OFF_IRQS = 8'h14;
	localparam logic [7:0] OFF_MASK = 8'h18;
	localparam logic [7:0] OFF_PWR0 = 8'h1C;
	localparam logic [7:0] OFF_PWR1 = 8'h20;
	localparam logic [7:0] OFF_CARR = 8'h24;
	// Field positions
	localparam int CTRL_CAL = 0;
	localparam int CTRL_ON = 1;
	localparam int CTRL_SLEEP = 2;
	localparam int CTRL_DATA = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FAIL = 1;
	localparam int IRQ_LOCK = 2;
	// Reset values and codes
	localparam logic [7:0] PWR0_RST = 8'hC6;
	localparam logic [5:0] CAL_FAIL = 6'h3F;
	localparam logic [5:0] SEL_LOCK = 6'h0A;
	localparam logic [1:0] AUTO_NONE = 2'h0;
	localparam logic [1:0] AUTO_ON = 2'h1;
	localparam logic [1:0] AUTO_OFF = 2'h2;
	localparam logic [15:0] CHSP_BASE = 16'h0100;
	// Calibration length, crystal clock periods
	localparam int CAL_CYCLES = 18739;
	// Radio operating states
	typedef enum logic [1:0] {
		SFP_IDLE,
		SFP_CAL,
		SFP_ON,
		SFP_SLEEP
	} sfp_state_e;
endpackage : sfp_pkg

// [inc/sfp_if.sv]
`timescale 1ns/1ps
interface sfp_if;
	logic [23:0] freq_word; // Base frequency word
	logic [7:0] channel_number; // Channel index
	logic [7:0] chan_spacing_mantissa; // Spacing mantissa
	logic [1:0] chan_spacing_exponent; // Spacing exponent
	logic [4:0] if_freq_setting; // IF setting
	logic [1:0] auto_cal_select; // Auto calibration mode
	logic [5:0] output_pin_select; // Output pin function
	logic [2:0] power_table_index; // Power table index
	logic [7:0] pwr_wr_data; // Table write data
	logic pwr_wr_en; // Table write pulse
	logic pwr_wr_addr; // Table entry select
	logic calibrate_strobe; // Calibration command pulse
	logic radio_on; // Synth turn-on level
	logic sleep_req; // Sleep request level
	logic tx_data; // OOK data bit
	logic pll_locked; // Analog lock input (bench)
	logic [5:0] synth_cal_result; // Calibration result
	logic general_output_pin; // Selected output pin
	logic cal_busy; // Calibration running
	logic [1:0] radio_state; // Current state
	logic [7:0] pa_power; // Selected PA code
	logic [31:0] carrier_word; // Carrier in f_xosc/2^18 units
	logic [31:0] if_word; // IF in f_xosc/2^10 units
	modport dev (
		input freq_word, channel_number, chan_spacing_mantissa,
		input chan_spacing_exponent, if_freq_setting, auto_cal_select,
		input output_pin_select, power_table_index, pwr_wr_data,
		input pwr_wr_en, pwr_wr_addr, calibrate_strobe, radio_on,
		input sleep_req, tx_data, pll_locked,
		output synth_cal_result, general_output_pin, cal_busy,
		output radio_state, pa_power, carrier_word, if_word
	);
	modport host (
		output freq_word, channel_number, chan_spacing_mantissa,
		output chan_spacing_exponent, if_freq_setting, auto_cal_select,
		output output_pin_select, power_table_index, pwr_wr_data,
		output pwr_wr_en, pwr_wr_addr, calibrate_strobe, radio_on,
		output sleep_req, tx_data,
		input synth_cal_result, general_output_pin, cal_busy,
		input radio_state, pa_power, carrier_word, if_word
	);
endinterface : sfp_if

// [design/sfp_dev.sv]
`timescale 1ns/1ps
module sfp_dev
	import sfp_pkg::*;
#(
	parameter int CAL_LEN = CAL_CYCLES
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Link to host
	sfp_if.dev lnk
);
	localparam logic [14:0] CAL_LAST = 15'(CAL_LEN - 1);

	sfp_state_e state_ff, nxt_state; // Radio state
	logic [14:0] cnt_ff; // Calibration counter
	logic [5:0] cal_ff; // Calibration result
	logic [7:0] pwr0_ff; // Table entry zero
	logic [7:0] pwr1_ff; // Table entry one
	logic on_d_ff; // Previous turn-on level
	logic [7:0] pa_ff; // Selected PA code
	logic [31:0] car_ff; // Carrier word
	logic [31:0] if_ff; // IF word

	// Spacing and carrier arithmetic
	// Everything is kept four times too large, so that the
	// exponent's minus two never drops a fraction bit.
	// Mantissa gets its implied 256 added
	wire [15:0] spc_mant = CHSP_BASE + {8'h00, lnk.chan_spacing_mantissa};
	// Shift by the exponent; 2^(exp-2) times 4 is 2^exp
	wire [17:0] spc_x4 = {2'b00, spc_mant} << lnk.chan_spacing_exponent;
	// Both operands widened first so the product cannot wrap
	// Largest product is 255 * 511 * 8, well inside 26 bits
	wire [25:0] chan_prod = 26'(lnk.channel_number) * 26'(spc_x4);
	// Base word scaled by 4 to match the spacing product
	wire [31:0] carr_sum = {6'h00, lnk.freq_word, 2'b00} + {6'h00, chan_prod};
	// Turn-on level edges, seen one cycle after the host writes
	wire on_rise = lnk.radio_on & ~on_d_ff;
	wire on_fall = ~lnk.radio_on & on_d_ff;
	// Last cycle of a calibration run
	// Counter starts at zero, so the run lasts CAL_LEN cycles
	wire cal_end = (state_ff == SFP_CAL) && (cnt_ff == CAL_LAST);
	// Turn-on calibration request
	wire cal_on = on_rise && (lnk.auto_cal_select == AUTO_ON);
	// Turn-off calibration request
	wire cal_off = on_fall && (lnk.auto_cal_select == AUTO_OFF);

	// Next state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			SFP_IDLE: begin
				if (lnk.sleep_req) begin
					nxt_state = SFP_SLEEP;
				end else if (lnk.calibrate_strobe || cal_on) begin
					nxt_state = SFP_CAL;
				end else if (on_rise) begin
					nxt_state = SFP_ON;
				end
			end
			SFP_CAL: begin
				// Turn-on calibration proceeds to ON
				if (cal_end) begin
					nxt_state = lnk.radio_on ? SFP_ON : SFP_IDLE;
				end
			end
			SFP_ON: begin
				if (on_fall) begin
					nxt_state = cal_off ? SFP_CAL : SFP_IDLE;
				end
			end
			SFP_SLEEP: begin
				if (!lnk.sleep_req) begin
					nxt_state = SFP_IDLE;
				end
			end
			default: nxt_state = SFP_IDLE;
		endcase
	end

	// State, counter and edge register
	// The edge register resets low, matching the idle level of
	// the turn-on bit, so no false turn-on follows reset.
	// The counter is cleared outside calibration so each run
	// starts from zero, whatever cut the previous one short.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_ff <= SFP_IDLE;
			cnt_ff <= 15'h0000;
			on_d_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			on_d_ff <= lnk.radio_on;
			cnt_ff <= (state_ff == SFP_CAL) ? cnt_ff + 15'h0001 : 15'h0000;
		end
	end

	// Calibration result; untouched by sleep so it stays valid
	// Reset value is the fail code: nothing is calibrated yet.
	// The locked code is a free choice; any value but the
	// fail code would do for software that polls the result.
	// Limitation: no real tuning word is modelled here.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cal_ff <= CAL_FAIL;
		end else if (cal_end) begin
			// Fail code only if lock missing, never while locked
			cal_ff <= lnk.pll_locked ? 6'h20 : CAL_FAIL;
		end else if (lnk.pll_locked && cal_ff == CAL_FAIL) begin
			cal_ff <= 6'h20;
		end
	end

	// Power table; sleep loses every entry but zero
	// Entry one is wiped on every sleep cycle, so a write that
	// arrives during sleep is lost too, like the real table.
	// Writes to either entry are ignored while asleep.
	// Only two entries are kept: OOK needs no more.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pwr0_ff <= PWR0_RST;
			pwr1_ff <= 8'h00;
		end else if (state_ff == SFP_SLEEP) begin
			pwr1_ff <= 8'h00;
		end else if (lnk.pwr_wr_en) begin
			if (lnk.pwr_wr_addr) begin
				pwr1_ff <= lnk.pwr_wr_data;
			end else begin
				pwr0_ff <= lnk.pwr_wr_data;
			end
		end
	end

	// Output data registers
	// All three outputs lag their inputs by one cycle; the
	// host reads them no earlier than the cycle after a write.
	// Registering the carrier word keeps the long adder path
	// out of the host's read multiplexer.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pa_ff <= 8'h00;
			car_ff <= 32'h0000_0000;
			if_ff <= 32'h0000_0000;
		end else begin
			// Index zero is fixed entry 0 for FSK
			if (lnk.power_table_index == 3'h0) begin
				pa_ff <= pwr0_ff;
			end else begin
				pa_ff <= lnk.tx_data ? pwr1_ff : pwr0_ff;
			end
			// Scaled by 4 to keep the 2^-2 bits exact
			car_ff <= carr_sum;
			if_ff <= {27'h0000000, lnk.if_freq_setting};
		end
	end

	// Result straight from its register
	assign lnk.synth_cal_result = cal_ff;
	// Lock detector on the pin only when selected; other codes
	// are not modelled and hold the pin low.
	// A rise here is what the host takes as lock.
	assign lnk.general_output_pin =
		(lnk.output_pin_select == SEL_LOCK) & lnk.pll_locked;
	// Busy is a plain decode of the state register
	assign lnk.cal_busy = (state_ff == SFP_CAL);
	// State exported so the host can refuse frequency writes and the strobe outside IDLE
	assign lnk.radio_state = state_ff;
	// Data words from their registers
	assign lnk.pa_power = pa_ff;
	assign lnk.carrier_word = car_ff;
	assign lnk.if_word = if_ff;
endmodule : sfp_dev

// [test/sfp_props.sv]
`timescale 1ns/1ps
module sfp_props
	import sfp_pkg::*;
#(
	parameter int CAL_LEN = 20
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Host to device, plus the bench lock input
	input wire logic [1:0] auto_cal_select,
	input wire logic [5:0] output_pin_select,
	input wire logic [2:0] power_table_index,
	input wire logic [7:0] pwr_wr_data,
	input wire logic pwr_wr_en,
	input wire logic pwr_wr_addr,
	input wire logic calibrate_strobe,
	input wire logic radio_on,
	input wire logic tx_data,
	input wire logic pll_locked,
	// Device to host
	input wire logic [5:0] synth_cal_result,
	input wire logic general_output_pin,
	input wire logic cal_busy,
	input wire logic [1:0] radio_state,
	input wire logic [7:0] pa_power
);
	default clocking dc @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	logic [7:0] e0_ff; // Entry zero shadow
	logic [7:0] e1_ff; // Entry one shadow
	logic [15:0] cnt_ff; // Busy run length
	// Table shadow; sleep wipes entry one
	wire [7:0] nxt_e0 = (pwr_wr_en && !pwr_wr_addr &&
		radio_state != SFP_SLEEP) ? pwr_wr_data : e0_ff;
	wire [7:0] nxt_e1 = (radio_state == SFP_SLEEP) ? 8'h00 :
		(pwr_wr_en && pwr_wr_addr) ? pwr_wr_data : e1_ff;
	wire [15:0] nxt_cnt = cal_busy ? cnt_ff + 16'h0001 : 16'h0000;
	// Code the device must pick one cycle later
	wire [7:0] pw_sel = (power_table_index != 3'h0 && tx_data) ? e1_ff : e0_ff;
	// Shadows follow writes, so no table readback is needed
	always_ff @(posedge i_clk) begin
		e0_ff <= i_rst ? PWR0_RST : nxt_e0;
		e1_ff <= i_rst ? 8'h00 : nxt_e1;
		cnt_ff <= i_rst ? 16'h0000 : nxt_cnt;
	end
	AST_PIN: assert property (general_output_pin ==
		(output_pin_select == SEL_LOCK && pll_locked)) else $error("pin bad");
	AST_CAL_LEN: assert property ($fell(cal_busy) |-> cnt_ff == CAL_LEN)
		else $error("cal length bad");
	AST_STROBE: assert property (calibrate_strobe &&
		radio_state == SFP_IDLE |-> ##[1:2] cal_busy) else $error("no cal");
	AST_AUTO_ON: assert property ($rose(radio_on) &&
		auto_cal_select == AUTO_ON && radio_state == SFP_IDLE |->
		##[1:2] cal_busy) else $error("no cal at turn-on");
	AST_AUTO_OFF: assert property ($fell(radio_on) &&
		auto_cal_select == AUTO_OFF && radio_state == SFP_ON |->
		##[1:2] cal_busy) else $error("no cal at turn-off");
	AST_LOCK: assert property ($fell(cal_busy) && pll_locked |->
		##[0:2] synth_cal_result != CAL_FAIL) else $error("lock code bad");
	AST_POWER: assert property (!i_rst |=> pa_power == $past(pw_sel))
		else $error("power code bad");
	AST_KEEP: assert property (radio_state == SFP_SLEEP && !pll_locked
		##1 !pll_locked |-> $stable(synth_cal_result)) else $error("cal lost");
	cover property ($fell(cal_busy));
	cover property (radio_state == SFP_SLEEP);
	cover property ($rose(general_output_pin));
endmodule : sfp_props

// [test/sfp_test.sv]
`timescale 1ns/1ps
module sfp_test;
	import sfp_pkg::*;
	localparam int CL = 20; // Short calibration keeps the run brief
	logic i_clk; // Clock
	logic i_rst; // Reset
	logic [7:0] haddr; // Bus address
	logic [1:0] htrans; // Transfer kind
	logic hwrite; // Direction
	logic [31:0] hwdata; // Write data
	logic [31:0] hrdata; // Read data
	logic hrdy; // Slave ready
	logic irq; // Interrupt
	logic hresp; // Slave response
	logic [31:0] rd; // Last read
	logic [31:0] car; // Expected carrier
	int n; // Busy run seen
	int cyc; // Cycle count
	int num_errors; // Mismatches
	int num_checks; // Compares
	sfp_if lnk(); // Link between ends
	sfp_host sfp_host_i (
		.i_clk(i_clk), .i_rst(i_rst), .i_hsel(1'b1), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
		.o_hreadyout(hrdy), .o_hresp(hresp), .o_irq(irq), .lnk(lnk)
	);
	sfp_dev #(.CAL_LEN(CL)) sfp_dev_i (.i_clk(i_clk), .i_rst(i_rst), .lnk(lnk));
	sfp_props #(.CAL_LEN(CL)) sfp_props_i (
		.i_clk(i_clk), .i_rst(i_rst),
		.auto_cal_select(lnk.auto_cal_select),
		.output_pin_select(lnk.output_pin_select),
		.power_table_index(lnk.power_table_index),
		.pwr_wr_data(lnk.pwr_wr_data), .pwr_wr_en(lnk.pwr_wr_en),
		.pwr_wr_addr(lnk.pwr_wr_addr), .tx_data(lnk.tx_data),
		.calibrate_strobe(lnk.calibrate_strobe), .radio_on(lnk.radio_on),
		.pll_locked(lnk.pll_locked), .cal_busy(lnk.cal_busy),
		.synth_cal_result(lnk.synth_cal_result), .pa_power(lnk.pa_power),
		.general_output_pin(lnk.general_output_pin),
		.radio_state(lnk.radio_state)
	);
	// One bus transfer; read data taken at the data phase's last edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge i_clk);
		while (hrdy !== 1'b1)
			@(posedge i_clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge i_clk);
		while (hrdy !== 1'b1)
			@(posedge i_clk);
		rd = hrdata;
	endtask : xfer
	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] v);
		num_checks++;
		if (v !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", s, e, v);
		end
	endtask : chk
	// Spare edge first: registered results lag a write by one cycle
	task automatic rc(input string s, input logic [7:0] a,
		input logic [31:0] e);
		@(posedge i_clk);
		xfer(1'b0, a, 32'h00000000);
		chk(s, e, rd);
	endtask : rc
	// Length of the next busy run, zero if none starts soon
	task automatic cw();
		n = 0;
		repeat (4) begin
			if (lnk.cal_busy !== 1'b1)
				@(posedge i_clk);
		end
		while (lnk.cal_busy === 1'b1 && n < 100) begin
			@(posedge i_clk);
			n++;
		end
	endtask : cw
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// Hang guard
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			end_sim();
		end
	end
	initial begin
		i_rst = 1'b1;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h00000000;
		lnk.pll_locked = 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		rc("pwr0", OFF_PWR0, 32'h000000C6);
		rc("unmapped", 8'h40, 32'h00000000);
		chk("hresp", 32'h00000000, {31'h0, hresp});
		$display("test reset done");
		xfer(1'b1, OFF_FREQ, 32'h00ABCDEF);
		for (int e = 0; e < 4; e++) begin
			xfer(1'b1, OFF_CHAN, {14'h0000, e[1:0], 16'h0001});
			car = 32'h02AF37BC + (32'h00000100 << e);
			rc("carrier", OFF_CARR, car);
		end
		xfer(1'b1, OFF_CHAN, 32'h0003FFFF);
		car = 32'h02AF37BC + ((32'h000000FF * 32'h000001FF) << 3);
		rc("carrier max", OFF_CARR, car);
		xfer(1'b1, OFF_IFRQ, 32'h0000001F);
		repeat (2) @(posedge i_clk);
		chk("if word", 32'h0000001F, lnk.if_word);
		$display("test freq done");
		lnk.pll_locked <= 1'b1;
		xfer(1'b1, OFF_MASK, 32'h00000007);
		xfer(1'b1, OFF_CTRL, 32'h00000A01);
		cw();
		chk("cal len", CL, n);
		rc("stat", OFF_STAT, 32'h00000201);
		chk("irq", 32'h00000001, {31'h0, irq});
		rc("irqs", OFF_IRQS, 32'h00000005);
		repeat (2) @(posedge i_clk);
		chk("irq clear", 32'h00000000, {31'h0, irq});
		$display("test cal done");
		lnk.pll_locked <= 1'b0;
		xfer(1'b1, OFF_PWR1, 32'h00000055);
		xfer(1'b1, OFF_CTRL, 32'h00004008);
		rc("ook one", OFF_PWR0, 32'h00000055);
		xfer(1'b1, OFF_CTRL, 32'h00004000);
		rc("ook zero", OFF_PWR0, 32'h000000C6);
		xfer(1'b1, OFF_CTRL, 32'h00000008);
		rc("fsk", OFF_PWR0, 32'h000000C6);
		xfer(1'b1, OFF_CTRL, 32'h0000400C);
		repeat (3) @(posedge i_clk);
		xfer(1'b1, OFF_CTRL, 32'h00004008);
		rc("entry one", OFF_PWR0, 32'h00000000);
		rc("cal kept", OFF_STAT, 32'h00000200);
		xfer(1'b1, OFF_CTRL, 32'h00000000);
		rc("entry zero", OFF_PWR0, 32'h000000C6);
		$display("test power done");
		xfer(1'b1, OFF_MASK, 32'h00000000);
		xfer(1'b1, OFF_CTRL, 32'h00000010);
		xfer(1'b1, OFF_CTRL, 32'h00000012);
		cw();
		chk("auto on", CL, n);
		xfer(1'b1, OFF_CTRL, 32'h00000013);
		cw();
		chk("strobe in on", 32'h00000000, n);
		xfer(1'b1, OFF_FREQ, 32'h00000000);
		rc("carrier held", OFF_CARR, car);
		xfer(1'b1, OFF_CTRL, 32'h00000022);
		xfer(1'b1, OFF_CTRL, 32'h00000020);
		cw();
		chk("auto off", CL, n);
		chk("masked", 32'h00000000, {31'h0, irq});
		rc("fail code", OFF_STAT, 32'h000003F0);
		xfer(1'b1, OFF_MASK, 32'h00000002);
		repeat (2) @(posedge i_clk);
		chk("irq fail", 32'h00000001, {31'h0, irq});
		rc("irqs fail", OFF_IRQS, 32'h00000003);
		$display("test auto done");
		end_sim();
	end
endmodule : sfp_test
